// ---- hdl/supply_gate_pkg.sv ----
// constants and types for the supply monitor and power-up gate
// assumes a single 25 MHz core clock and active-low async reset
`default_nettype none
package supply_gate_pkg;
  localparam int unsigned CLK_HZ           = 25_000_000;
  localparam int unsigned DBNC_10_US       = 10;
  localparam int unsigned DBNC_100_US      = 100;
  localparam int unsigned DBNC_1000_US     = 1000;
  localparam int unsigned DBNC_10_CYC      = DBNC_10_US * (CLK_HZ / 1_000_000);
  localparam int unsigned DBNC_100_CYC     = DBNC_100_US * (CLK_HZ / 1_000_000);
  localparam int unsigned DBNC_1000_CYC    = DBNC_1000_US * (CLK_HZ / 1_000_000);
  localparam int unsigned FUSE_LOAD_US     = 600;
  localparam int unsigned FUSE_LOAD_CYC    = FUSE_LOAD_US * (CLK_HZ / 1_000_000);
  localparam int unsigned SELFTEST_LPM_US  = 700;
  localparam int unsigned SELFTEST_LPM_CYC = SELFTEST_LPM_US * (CLK_HZ / 1_000_000);
  localparam int unsigned FIRST_SLOT_US    = 100;
  localparam int unsigned FIRST_SLOT_CYC   = FIRST_SLOT_US * (CLK_HZ / 1_000_000);
  localparam int unsigned HOST_RST_US      = 1500;
  localparam int unsigned HOST_RST_CYC     = HOST_RST_US * (CLK_HZ / 1_000_000);
  localparam int unsigned POWER_ON_DEBOUNCE_TIMER_US    = 32;
  localparam int unsigned POWER_ON_DEBOUNCE_TIMER_CYC   = POWER_ON_DEBOUNCE_TIMER_US * (CLK_HZ / 1_000_000);
  localparam int unsigned CNT_W            = 16;

  // register map, byte addresses
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_EVENT  = 12'h008;

  // control register fields
  localparam int unsigned CTRL_OV_EN   = 0;
  localparam int unsigned CTRL_OV_SDWN = 1;
  localparam int unsigned CTRL_DBNC_LO = 2;
  localparam int unsigned CTRL_LPOFF   = 4;

  // event register fields (write one to clear)
  localparam int unsigned EVT_OV_IRQ  = 0;
  localparam int unsigned EVT_OV_SDWN = 1;
  localparam int unsigned EVT_ABORT   = 2;

  localparam logic [1:0] DBNC_RESERVED = 2'h3;

  typedef enum logic [2:0] {
    ST_UNPOWERED = 3'b000,
    ST_COIN_CELL = 3'b001,
    ST_FUSE_LOAD = 3'b010,
    ST_LOW_POWER_OFF_STATE    = 3'b011,
    ST_SELF_TEST = 3'b100,
    ST_FIRST     = 3'b101,
    ST_REG_UP    = 3'b110,
    ST_RUN       = 3'b111
  } gate_state_t;
endpackage : supply_gate_pkg
`default_nettype wire

// ---- hdl/supply_monitor_powerup_gate.sv ----
// supply supervision, fuse-load gating and power-up qualification
// assumes comparator and pin inputs are asynchronous; APB on core_clk
`default_nettype none
module supply_monitor_powerup_gate
  import supply_gate_pkg::*;
#(
  parameter int unsigned FUSE_LOAD_CYCLES  = FUSE_LOAD_CYC,
  parameter int unsigned SELF_TEST_CYCLES  = SELFTEST_LPM_CYC,
  parameter int unsigned HOST_RST_CYCLES   = HOST_RST_CYC,
  parameter int unsigned DBNC_1000_CYCLES  = DBNC_1000_CYC
)(
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        supplyValidThreshold,
  input  wire logic        coinCellInput,
  input  wire logic        inputOvervoltageLockout,
  input  wire logic        overTemperature,
  input  wire logic        powerOnRequestPin,
  input  wire logic        powerOnPinSensitivity,
  input  wire logic        fusedOvervoltageEnableDefault,
  input  wire logic        fusedOvervoltageShutdownDefault,
  input  wire logic [1:0]  fusedDebounceDefault,
  input  wire logic        trimFaultFlag,
  input  wire logic        fuseFaultFlag,
  input  wire logic        selfTestFaultFlag,
  input  wire logic        fuseLoadDone,
  input  wire logic        selfTestDone,
  input  wire logic        lastSlotDone,
  output logic             fuseLoadStart,
  output logic             coreBiasEnable,
  output logic             coinCellMode,
  output logic             selfTestStart,
  output logic             firstSlotStart,
  output logic             powerDownRequest,
  output logic             overvoltageInterrupt,
  output logic             hostResetOutput_n,
  output logic             budgetViolation
);
  // two-flop synchronisers for all asynchronous inputs
  localparam int unsigned NSYNC = 11;
  logic [NSYNC-1:0] asyncIn;
  logic [NSYNC-1:0] syncA_reg;
  logic [NSYNC-1:0] syncB_reg;
  // mode strap synchronised too, so a live change cannot glitch the event select
  assign asyncIn = {supplyValidThreshold, coinCellInput, inputOvervoltageLockout,
                    overTemperature, powerOnRequestPin, trimFaultFlag, fuseFaultFlag,
                    selfTestFaultFlag, fuseLoadDone, selfTestDone, powerOnPinSensitivity};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++)
    begin : g_sync
      always_ff @(posedge core_clk or negedge resetn)
      begin
        if (!resetn)
        begin
          syncA_reg[gi] <= 1'b0;
          syncB_reg[gi] <= 1'b0;
        end
        else
        begin
          syncA_reg[gi] <= asyncIn[gi];
          syncB_reg[gi] <= syncA_reg[gi];
        end
      end
    end
  endgenerate

  logic supplyOk, coinOk, ovRaw, hotSync, pinSync, trimBad, fuseBad, testBad;
  logic fuseDoneSync, testDoneSync, sensSync;
  assign {supplyOk, coinOk, ovRaw, hotSync, pinSync, trimBad, fuseBad, testBad,
          fuseDoneSync, testDoneSync, sensSync} = syncB_reg;

  // supply edge detection on the synchronised level
  logic supplyOkDly_reg;
  logic pinDly_reg;
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      supplyOkDly_reg <= 1'b0;
      pinDly_reg      <= 1'b0;
    end
    else
    begin
      supplyOkDly_reg <= supplyOk;
      pinDly_reg      <= pinSync;
    end
  end
  wire supplyRise = supplyOk & ~supplyOkDly_reg;
  wire pinRise    = pinSync & ~pinDly_reg;
  wire pinFall    = ~pinSync & pinDly_reg;

  // control register
  logic       ovEnable_reg;
  logic       ovShutdown_reg;
  logic [1:0] ovDbnc_reg;
  logic       lpOffSelect_reg;
  logic       shutdownDefault_reg;
  logic [2:0] events_reg;
  gate_state_t state_reg, state_next;

  wire apbAccess  = psel & penable;
  wire apbWrite   = apbAccess & pwrite;
  wire selCtrl    = (paddr == ADDR_CTRL);
  wire selStatus  = (paddr == ADDR_STATUS);
  wire selEvent   = (paddr == ADDR_EVENT);
  wire addrHit    = selCtrl | selStatus | selEvent;
  // control writes only in run, so boot never sees half-loaded settings
  wire ctrlWrite  = apbWrite & selCtrl & (state_reg == ST_RUN);
  wire eventWrite = apbWrite & selEvent;
  wire [1:0] wrDbnc = pwdata[CTRL_DBNC_LO +: 2];

  // fuses copied only once the supply has crossed the threshold
  wire fuseCopy = (state_reg == ST_FUSE_LOAD) & fuseDoneSync;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ovEnable_reg        <= 1'b0;
      ovShutdown_reg      <= 1'b0;
      ovDbnc_reg          <= 2'h0;
      shutdownDefault_reg <= 1'b0;
    end
    else if (fuseCopy)
    begin
      ovEnable_reg        <= fusedOvervoltageEnableDefault;
      ovShutdown_reg      <= fusedOvervoltageShutdownDefault;
      ovDbnc_reg          <= fusedDebounceDefault;
      shutdownDefault_reg <= fusedOvervoltageShutdownDefault;
    end
    else if (ctrlWrite)
    begin
      ovEnable_reg   <= pwdata[CTRL_OV_EN];
      ovShutdown_reg <= pwdata[CTRL_OV_SDWN];
      // reserved code ignored so the debounce always has a defined length
      if (wrDbnc != DBNC_RESERVED)
        ovDbnc_reg <= wrDbnc;
    end
  end

  // low-power-off select: cleared on each crossing, else loaded by a control write, else kept
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      lpOffSelect_reg <= 1'b0;
    else if (supplyRise)
      lpOffSelect_reg <= 1'b0;
    else if (ctrlWrite)
      lpOffSelect_reg <= pwdata[CTRL_LPOFF];
  end

  // overvoltage debounce
  logic [CNT_W-1:0] ovCnt_reg;
  logic             ovEvent_reg;
  wire  [CNT_W-1:0] ovLimit = (ovDbnc_reg == 2'h0) ? CNT_W'(DBNC_10_CYC) :
                              (ovDbnc_reg == 2'h1) ? CNT_W'(DBNC_100_CYC) :
                                                     CNT_W'(DBNC_1000_CYCLES);
  wire ovActive = ovRaw & ovEnable_reg;
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ovCnt_reg   <= '0;
      ovEvent_reg <= 1'b0;
    end
    else if (!ovActive)
    begin
      ovCnt_reg   <= '0;
      ovEvent_reg <= 1'b0;
    end
    else if (ovCnt_reg >= ovLimit - CNT_W'(1))
      ovEvent_reg <= 1'b1;
    else
      ovCnt_reg <= ovCnt_reg + CNT_W'(1);
  end
  logic ovEventDly_reg;
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      ovEventDly_reg <= 1'b0;
    else
      ovEventDly_reg <= ovEvent_reg;
  end
  wire ovNew = ovEvent_reg & ~ovEventDly_reg;

  // power-on pin event, level or debounced falling edge
  logic [CNT_W-1:0] pinCnt_reg;
  logic             pinArmed_reg;
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pinCnt_reg   <= '0;
      pinArmed_reg <= 1'b0;
    end
    else if (pinFall)
    begin
      pinCnt_reg   <= '0;
      pinArmed_reg <= 1'b1;
    end
    else if (pinSync)
      pinArmed_reg <= 1'b0;
    else if (pinArmed_reg && pinCnt_reg != CNT_W'(POWER_ON_DEBOUNCE_TIMER_CYC))
      pinCnt_reg <= pinCnt_reg + CNT_W'(1);
    else
      pinArmed_reg <= 1'b0;
  end
  // one-cycle event per press: a pin left low cannot restart an aborted power-up;
  // an event refused by the qualification is dropped, not queued
  wire edgeEvent  = pinArmed_reg & (pinCnt_reg == CNT_W'(POWER_ON_DEBOUNCE_TIMER_CYC));
  wire powerEvent = sensSync ? edgeEvent : pinSync;

  // qualification of a power-up event
  // fused default, not the live bit, decides whether overvoltage blocks power-up
  wire ovBlocks   = ovEvent_reg & shutdownDefault_reg;
  wire upAllowed  = supplyOk & ~ovBlocks & ~hotSync &
                    ~trimBad & ~fuseBad & ~testBad;
  wire ovShutdown = ovEvent_reg & ovEnable_reg & ovShutdown_reg;

  // budget timer, restarted on each phase entry
  logic [CNT_W-1:0] phaseCnt_reg;
  logic             budgetViolation_reg;
  wire phaseChange = (state_next != state_reg);
  wire [CNT_W-1:0] phaseLimit =
    (state_reg == ST_FUSE_LOAD) ? CNT_W'(FUSE_LOAD_CYCLES) :
    (state_reg == ST_SELF_TEST) ? CNT_W'(SELF_TEST_CYCLES) :
    (state_reg == ST_FIRST)     ? CNT_W'(FIRST_SLOT_CYC) :
                                  CNT_W'(HOST_RST_CYCLES);
  wire phaseExpired = (phaseCnt_reg >= phaseLimit);

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      phaseCnt_reg <= '0;
    else if (phaseChange)
      phaseCnt_reg <= '0;
    else if (!phaseExpired)
      phaseCnt_reg <= phaseCnt_reg + CNT_W'(1);
  end

  // state machine
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_UNPOWERED, ST_COIN_CELL:
      begin
        if (supplyOk)
          state_next = ST_FUSE_LOAD;
        else
          state_next = coinOk ? ST_COIN_CELL : ST_UNPOWERED;
      end
      ST_FUSE_LOAD:
        if (fuseDoneSync)
          state_next = ST_LOW_POWER_OFF_STATE;
      ST_LOW_POWER_OFF_STATE:
        if (powerEvent && upAllowed)
          state_next = ST_SELF_TEST;
      ST_SELF_TEST:
        if (testDoneSync)
          state_next = ST_FIRST;
      ST_FIRST:
        state_next = (ovBlocks) ? ST_LOW_POWER_OFF_STATE : ST_REG_UP;
      // a missing last-slot report must not strand the host in reset
      ST_REG_UP:
        if (ovBlocks)
          state_next = ST_LOW_POWER_OFF_STATE;
        else if (lastSlotDone || phaseExpired)
          state_next = ST_RUN;
      ST_RUN:
        if (ovShutdown)
          state_next = ST_LOW_POWER_OFF_STATE;
      default:
        state_next = ST_UNPOWERED;
    endcase
    if (!supplyOk && state_reg != ST_UNPOWERED && state_reg != ST_COIN_CELL)
      state_next = coinOk ? ST_COIN_CELL : ST_UNPOWERED;
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      state_reg <= ST_UNPOWERED;
    else
      state_reg <= state_next;
  end

  // budget overrun is sticky until the supply cycles
  wire budgetMiss = phaseExpired & ~phaseChange &
                    ((state_reg == ST_FUSE_LOAD) | (state_reg == ST_SELF_TEST));
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      budgetViolation_reg <= 1'b0;
    else if (budgetMiss)
      budgetViolation_reg <= 1'b1;
    else if (supplyRise)
      budgetViolation_reg <= 1'b0;
  end

  // events: hardware set wins over software clear
  wire abortEvt = ovBlocks & ((state_reg == ST_FIRST) | (state_reg == ST_REG_UP));
  wire [2:0] evtSet;
  assign evtSet[EVT_OV_IRQ]  = ovNew & ~ovShutdown_reg;
  assign evtSet[EVT_OV_SDWN] = ovShutdown & (state_reg == ST_RUN);
  assign evtSet[EVT_ABORT]   = abortEvt;
  wire [2:0] evtClr = eventWrite ? pwdata[2:0] : 3'h0;
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      events_reg <= 3'h0;
    else
      events_reg <= evtSet | (events_reg & ~evtClr);
  end

  // registered outputs
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      fuseLoadStart        <= 1'b0;
      coreBiasEnable       <= 1'b0;
      coinCellMode         <= 1'b0;
      selfTestStart        <= 1'b0;
      firstSlotStart       <= 1'b0;
      powerDownRequest     <= 1'b0;
      overvoltageInterrupt <= 1'b0;
      hostResetOutput_n    <= 1'b0;
      budgetViolation      <= 1'b0;
    end
    else
    begin
      fuseLoadStart        <= (state_reg == ST_FUSE_LOAD);
      coreBiasEnable       <= (state_reg != ST_UNPOWERED) && (state_reg != ST_COIN_CELL);
      coinCellMode         <= (state_reg == ST_COIN_CELL);
      selfTestStart        <= (state_reg == ST_SELF_TEST);
      firstSlotStart       <= (state_reg == ST_FIRST);
      powerDownRequest     <= (state_reg == ST_RUN) & ovShutdown;
      overvoltageInterrupt <= events_reg[EVT_OV_IRQ];
      hostResetOutput_n    <= (state_reg == ST_RUN);
      budgetViolation      <= budgetViolation_reg;
    end
  end

  // apb read data, zero wait states
  wire [31:0] ctrlRead   = {27'h0, lpOffSelect_reg, ovDbnc_reg, ovShutdown_reg, ovEnable_reg};
  wire [31:0] statusRead = {22'h0, budgetViolation_reg, ovEvent_reg, shutdownDefault_reg,
                            sensSync, pinSync, supplyOk, 1'b0, state_reg};
  wire [31:0] eventRead  = {29'h0, events_reg};
  wire [31:0] readMux    = selCtrl   ? ctrlRead :
                           selStatus ? statusRead :
                           selEvent  ? eventRead : 32'h0;
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      prdata <= 32'h0;
    else if (psel && !penable && !pwrite)
      prdata <= readMux;
  end
  assign pready  = 1'b1;
  assign pslverr = apbAccess & ~addrHit;
endmodule : supply_monitor_powerup_gate
`default_nettype wire

// ---- bench/supply_partner_model.sv ----
// analog side model: fuse load, self-test and slot completion levels
// same core clock as the gate; delay in cycles is set by the bench
`default_nettype none
module supply_partner_model
(
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic [15:0] delay,
  input  wire logic        fuseLoadStart,
  input  wire logic        selfTestStart,
  input  wire logic        firstSlotStart,
  output logic             fuseLoadDone,
  output logic             selfTestDone,
  output logic             lastSlotDone
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] phaseCnt_reg;
  logic        slotRun_reg;
  logic        busy;
  assign busy = fuseLoadStart | selfTestStart | slotRun_reg;
  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn)
    begin
      phaseCnt_reg <= 16'h0000;
      slotRun_reg  <= 1'b0;
    end
    else
    begin
      slotRun_reg  <= firstSlotStart | (slotRun_reg & ~fuseLoadStart);
      phaseCnt_reg <= (firstSlotStart | ~busy) ? 16'h0000 : phaseCnt_reg + {15'h0000, ~&phaseCnt_reg};
    end
  // done levels fall with their start, never left standing stale
  assign fuseLoadDone = fuseLoadStart & (phaseCnt_reg >= delay);
  assign selfTestDone = selfTestStart & (phaseCnt_reg >= delay);
  // later slots leave the backup supply time to settle
  assign lastSlotDone = slotRun_reg & (phaseCnt_reg >= delay);
endmodule : supply_partner_model
`default_nettype wire

// ---- bench/supply_gate_assertions.sv ----
// port assertions for the supply monitor and power-up gate
// bound into the gate; one core_clk domain, resetn async low
`default_nettype none
module supply_gate_checker
#(
  parameter int unsigned HOST_RST_CYCLES = 37500
)(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic supplyValidThreshold,
  input wire logic coinCellInput,
  input wire logic inputOvervoltageLockout,
  input wire logic overTemperature,
  input wire logic powerOnRequestPin,
  input wire logic powerOnPinSensitivity,
  input wire logic trimFaultFlag,
  input wire logic fuseFaultFlag,
  input wire logic selfTestFaultFlag,
  input wire logic selfTestDone,
  input wire logic fuseLoadStart,
  input wire logic coreBiasEnable,
  input wire logic coinCellMode,
  input wire logic selfTestStart,
  input wire logic firstSlotStart,
  input wire logic overvoltageInterrupt,
  input wire logic hostResetOutput_n,
  input wire logic budgetViolation
);
  logic [11:0] ovRun_reg;
  logic [15:0] relCnt_reg;
  logic        anyFault;
  assign anyFault = overTemperature | trimFaultFlag | fuseFaultFlag | selfTestFaultFlag;
  // run length of overvoltage, and wait from first slot to reset release
  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn)
    begin
      ovRun_reg  <= 12'h000;
      relCnt_reg <= 16'h0000;
    end
    else
    begin
      ovRun_reg  <= inputOvervoltageLockout ? ovRun_reg + {11'h000, ~&ovRun_reg} : 12'h000;
      // an overvoltage may abort the power-up unseen at the ports: stop timing then
      relCnt_reg <= firstSlotStart ? 16'h0001 :
                    (hostResetOutput_n | ~coreBiasEnable | inputOvervoltageLockout |
                     ~|relCnt_reg) ? 16'h0000 :
                    relCnt_reg + 16'h0001;
    end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  sequence s_noSupply;
    (!supplyValidThreshold && $stable(coinCellInput)) [*6];
  endsequence
  sequence s_faultHeld;
    anyFault [*6];
  endsequence
  sequence s_pinLowLevel;
    (!powerOnRequestPin && !powerOnPinSensitivity) [*6];
  endsequence
  property p_noSupply;
    s_noSupply |-> !coreBiasEnable && !hostResetOutput_n && coinCellMode == coinCellInput;
  endproperty
  property p_needBias;
    (fuseLoadStart || selfTestStart || firstSlotStart) |-> coreBiasEnable;
  endproperty
  property p_faultBlock;
    s_faultHeld |-> !$rose(selfTestStart);
  endproperty
  property p_levelBlock;
    s_pinLowLevel |-> !$rose(selfTestStart);
  endproperty
  property p_firstSlot;
    ($rose(selfTestDone) && selfTestStart) |-> ##[1:1000] firstSlotStart;
  endproperty
  property p_firstPulse;
    firstSlotStart |=> !firstSlotStart;
  endproperty
  property p_hostRelease;
    relCnt_reg <= HOST_RST_CYCLES + 4;
  endproperty
  property p_ovDebounce;
    $rose(overvoltageInterrupt) |-> $past(ovRun_reg, 4) >= 12'h014;
  endproperty
  property p_budget;
    $rose(budgetViolation) |-> fuseLoadStart || selfTestStart || $past(selfTestStart);
  endproperty
  a_noSupply: assert property (p_noSupply) else $error("active without supply");
  a_needBias: assert property (p_needBias) else $error("start without bias");
  a_faultBlock: assert property (p_faultBlock) else $error("start despite fault");
  a_levelBlock: assert property (p_levelBlock) else $error("start with pin low");
  a_firstSlot: assert property (p_firstSlot) else $error("first slot late");
  a_firstPulse: assert property (p_firstPulse) else $error("first slot not a pulse");
  a_hostRelease: assert property (p_hostRelease) else $error("host reset late");
  a_ovDebounce: assert property (p_ovDebounce) else $error("overvoltage not debounced");
  a_budget: assert property (p_budget) else $error("budget flag out of phase");
endmodule : supply_gate_checker
bind supply_monitor_powerup_gate supply_gate_checker #(.HOST_RST_CYCLES(HOST_RST_CYCLES)) u_chk (
  .core_clk, .resetn, .supplyValidThreshold, .coinCellInput, .inputOvervoltageLockout,
  .overTemperature, .powerOnRequestPin, .powerOnPinSensitivity, .trimFaultFlag,
  .fuseFaultFlag, .selfTestFaultFlag, .selfTestDone, .fuseLoadStart, .coreBiasEnable,
  .coinCellMode, .selfTestStart, .firstSlotStart, .overvoltageInterrupt,
  .hostResetOutput_n, .budgetViolation);
`default_nettype wire

// ---- bench/tb_supply_monitor_powerup_gate.sv ----
// self-checking bench for the supply monitor and power-up gate
// assumes package, partner model and bound checker compiled first
`default_nettype none
module tb_supply_monitor_powerup_gate
  import supply_gate_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk, resetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        sv, coin, ov, hot, pin, sens, fEn, fSd, trim, fuseF, stF;
  logic [1:0]  fDb;
  logic        fuseDone, testDone, slotDone, fuseGo, biasOn, coinMode, testGo, firstGo;
  logic        pdReq, ovIrq, hostRst_n, budget;
  logic [15:0] pDelay;
  logic [31:0] expQ[$], mskQ[$];
  logic        errQ[$];
  int          n_mismatch, check_count, seed, hold;
  logic [31:0] ovCtl[7] = '{32'h01, 32'h01, 32'h05, 32'h05, 32'h09, 32'h09, 32'h00};
  int          ovHold[7] = '{100, 300, 600, 2600, 12, 60, 300};
  logic [6:0]  ovExp = 7'h2A;
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  supply_monitor_powerup_gate #(.FUSE_LOAD_CYCLES(20), .SELF_TEST_CYCLES(20),
    .HOST_RST_CYCLES(40), .DBNC_1000_CYCLES(30)) DUT (
    .core_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .supplyValidThreshold(sv), .coinCellInput(coin), .inputOvervoltageLockout(ov),
    .overTemperature(hot), .powerOnRequestPin(pin), .powerOnPinSensitivity(sens),
    .fusedOvervoltageEnableDefault(fEn), .fusedOvervoltageShutdownDefault(fSd),
    .fusedDebounceDefault(fDb), .trimFaultFlag(trim), .fuseFaultFlag(fuseF),
    .selfTestFaultFlag(stF), .fuseLoadDone(fuseDone), .selfTestDone(testDone),
    .lastSlotDone(slotDone), .fuseLoadStart(fuseGo), .coreBiasEnable(biasOn),
    .coinCellMode(coinMode), .selfTestStart(testGo), .firstSlotStart(firstGo),
    .powerDownRequest(pdReq), .overvoltageInterrupt(ovIrq), .hostResetOutput_n(hostRst_n),
    .budgetViolation(budget));
  supply_partner_model PARTNER (.core_clk, .resetn, .delay(pDelay), .fuseLoadStart(fuseGo),
    .selfTestStart(testGo), .firstSlotStart(firstGo), .fuseLoadDone(fuseDone),
    .selfTestDone(testDone), .lastSlotDone(slotDone));
  task automatic fail(input string msg);
    n_mismatch++;
    $display("CHECK FAILED at %0t: %s", $time, msg);
  endtask : fail
  task automatic chk(input logic got, input logic exp, input string msg);
    check_count++;
    if (got !== exp)
      fail(msg);
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc
  // bounded poll a step after each edge, then realign to an edge
  task automatic waitFor(ref logic s, input logic v, input string msg);
    int n;
    n = 0;
    while (s !== v && n < 4000)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk(s, v, msg);
    @(posedge core_clk);
  endtask : waitFor
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do
      @(posedge core_clk);
    while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
                    input logic er);
    mskQ.push_back(m);
    expQ.push_back(e & m);
    errQ.push_back(er);
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic st(input gate_state_t s, input logic b);
    rd(ADDR_STATUS, 32'h207, {22'h0, b, 6'h0, s}, 1'b0);
  endtask : st
  task automatic powerCycle;
    sv  <= 1'b0;
    pin <= 1'b0;
    cyc(8);
    sv <= 1'b1;
    waitFor(fuseGo, 1'b1, "fuse load not started");
    waitFor(fuseGo, 1'b0, "fuse load not finished");
    st(ST_LOW_POWER_OFF_STATE, 1'b0);
  endtask : powerCycle
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim
  always @(posedge core_clk)
    if (psel && penable && pready === 1'b1 && !pwrite && expQ.size() > 0)
    begin
      check_count++;
      if ((prdata & mskQ[0]) !== expQ[0] || pslverr !== errQ[0])
        fail("register read differs");
      void'(expQ.pop_front());
      void'(mskQ.pop_front());
      void'(errQ.pop_front());
    end
  initial
  begin
    #(40 * 40000);
    fail("watchdog expired");
    end_sim();
  end
  initial
  begin
    seed = 32'h35FF4A29;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {sv, coin, ov, hot, pin, sens, fEn, fSd, fDb, trim, fuseF, stF} = '0;
    fEn = 1'b1;
    fDb = 2'b10;
    pDelay = 16'h0005;
    resetn = 1'b0;
    cyc(4);
    resetn <= 1'b1;
    cyc(8);
    st(ST_UNPOWERED, 1'b0);
    chk(biasOn, 1'b0, "bias without supply");
    coin <= 1'b1;
    cyc(8);
    st(ST_COIN_CELL, 1'b0);
    chk(coinMode, 1'b1, "coin-cell mode off");
    rd(12'h0FC, 32'hFFFFFFFF, 32'h0, 1'b1);
    $display("test supply absent done");
    powerCycle();
    rd(ADDR_CTRL, 32'h1F, 32'h09, 1'b0);
    pin <= 1'b1;
    waitFor(firstGo, 1'b1, "first slot missing");
    waitFor(hostRst_n, 1'b1, "host reset held");
    rd(ADDR_STATUS, 32'h207, {29'h0, ST_RUN}, 1'b0);
    $display("test level power-up done");
    foreach (ovCtl[i])
    begin
      apb(1'b1, ADDR_CTRL, ovCtl[i]);
      hold = ovHold[i] + ($random(seed) & 15);
      ov <= 1'b1;
      cyc(hold);
      ov <= 1'b0;
      cyc(8);
      chk(ovIrq, ovExp[i], "interrupt pin");
      rd(ADDR_EVENT, 32'h3, {31'h0, ovExp[i]}, 1'b0);
      apb(1'b1, ADDR_EVENT, 32'h7);
    end
    apb(1'b1, ADDR_CTRL, 32'h0D);
    rd(ADDR_CTRL, 32'h0C, 32'h0, 1'b0);
    st(ST_RUN, 1'b0);
    $display("test overvoltage debounce done");
    apb(1'b1, ADDR_CTRL, 32'h13);
    rd(ADDR_CTRL, 32'h1F, 32'h13, 1'b0);
    ov <= 1'b1;
    waitFor(pdReq, 1'b1, "no power down");
    ov <= 1'b0;
    rd(ADDR_EVENT, 32'h2, 32'h2, 1'b0);
    fSd <= 1'b1;
    powerCycle();
    rd(ADDR_CTRL, 32'h13, 32'h03, 1'b0);
    $display("test overvoltage shutdown done");
    for (int k = 0; k < 5; k++)
    begin
      {ov, hot, trim, fuseF, stF} <= 5'h10 >> k;
      cyc(300);
      pin <= 1'b1;
      cyc(40);
      st(ST_LOW_POWER_OFF_STATE, 1'b0);
      {ov, hot, trim, fuseF, stF, pin} <= 6'h0;
      cyc(8);
    end
    $display("test power-up qualification done");
    sens   <= 1'b1;
    pDelay <= 16'h0258;
    pin    <= 1'b1;
    cyc(20);
    pin <= 1'b0;
    waitFor(testGo, 1'b1, "edge event missed");
    ov <= 1'b1;
    waitFor(testGo, 1'b0, "power-up not aborted");
    ov <= 1'b0;
    rd(ADDR_EVENT, 32'h4, 32'h4, 1'b0);
    st(ST_LOW_POWER_OFF_STATE, 1'b1);
    chk(budget, 1'b1, "budget overrun not flagged");
    $display("test edge abort done");
    fSd    <= 1'b0;
    sens   <= 1'b0;
    pDelay <= 16'h0005;
    powerCycle();
    ov  <= 1'b1;
    pin <= 1'b1;
    waitFor(hostRst_n, 1'b1, "power-up blocked by overvoltage");
    cyc(300);
    chk(ovIrq, 1'b1, "no overvoltage interrupt");
    ov <= 1'b0;
    cyc(4);
    $display("test overvoltage power-up done");
    end_sim();
  end
endmodule : tb_supply_monitor_powerup_gate
`default_nettype wire
